// *** pkg/cprs_defines.vh ***
// Constants for the processor programmer register set.
// Assumes inclusion by bare name from the register set design files.
`ifndef CPRS_DEFINES_VH
`define CPRS_DEFINES_VH

// ---------------------------------------------------------------
// Stack
// ---------------------------------------------------------------
`define CPRS_SP_BITS        6
`define CPRS_SP_RESET       6'h3f
`define CPRS_SP_PAGE        10'h003
`define CPRS_STACK_DEPTH    64
`define CPRS_CALL_BYTES     3'h2
`define CPRS_IRQ_BYTES      3'h5

// ---------------------------------------------------------------
// Condition codes
// ---------------------------------------------------------------
`define CPRS_CC_C           0
`define CPRS_CC_Z           1
`define CPRS_CC_N           2
`define CPRS_CC_I           3
`define CPRS_CC_H           4
`define CPRS_CC_UPPER       3'h7

// ---------------------------------------------------------------
// Index modes and stacking order
// ---------------------------------------------------------------
`define CPRS_IDX_NONE       2'h0
`define CPRS_IDX_OFF8       2'h1
`define CPRS_IDX_OFF16      2'h2

`define CPRS_STK_PCL        3'h0
`define CPRS_STK_PCH        3'h1
`define CPRS_STK_X          3'h2
`define CPRS_STK_A          3'h3
`define CPRS_STK_CC         3'h4

`endif

// *** rtl/cprs_stack_ptr.v ***
// Six-bit stack pointer with fixed-page address forming.
// Assumes push and pull strobes never assert together.
`timescale 1ns/1ps
`include "cprs_defines.vh"

module cprs_stack_ptr (
  input  wire        clk_sys,     // Core clock.
  input  wire        nrst,        // Asynchronous reset, active low.
  input  wire        sp_reset,    // Stack top restore instruction.
  input  wire        push,        // One byte pushed.
  input  wire        pull,        // One byte pulled.
  output wire [15:0] stack_addr,  // Address of next free location.
  output wire [5:0]  stack_pointer // Implemented pointer bits.
);

  reg [5:0] sp_reg;
  reg [5:0] sp_next;

  always @* begin
    sp_next = sp_reg;
    if (sp_reset) begin
      sp_next = `CPRS_SP_RESET;                      // [RULE3]
    end else if (push) begin
      sp_next = sp_reg - 6'h01;                      // [RULE4] [RULE1]
    end else if (pull) begin
      sp_next = sp_reg + 6'h01;                      // [RULE4]
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sp_reg <= `CPRS_SP_RESET;                      // [RULE3]
    end else begin
      sp_reg <= sp_next;
    end
  end

  assign stack_addr    = {`CPRS_SP_PAGE, sp_reg};    // [RULE2]
  assign stack_pointer = sp_reg;

endmodule // cprs_stack_ptr

// *** rtl/cprs_regs.v ***
// Programmer-visible register set of the processor core.
// Assumes the sequencer issues one operation strobe per cycle.
//
// What this block does
// RULE1: Stack pointer has six bits and wraps from lowest to highest stack address.
// RULE2: Stack address is fixed upper ten bits joined with six pointer bits.
// RULE3: Reset and stack top restore instruction load top-of-stack address.
// RULE4: Pointer marks next free byte; push decrements, pull increments.
// RULE5: Call uses two stack bytes, interrupt five; sixty-four locations.
// RULE6: Accumulator is eight bits and keeps its value through reset.
// RULE7: Indexed without offset uses index as low byte, zero high byte.
// RULE8: One-byte offset mode adds index and eight-bit immediate.
// RULE9: Two-byte offset mode adds index and sixteen-bit immediate.
// RULE10: Index register is eight bits, temporary storage, kept through reset.
// RULE11: Program counter is sixteen bits; unimplemented upper bits ignored.
// RULE12: Counter increments per fetch; jumps, branches, interrupts load target.
// RULE13: Condition codes have five bits; upper three read as ones.
// RULE14: Reset changes only the interrupt mask among condition codes.
// RULE15: Result flags update from the outcome of the executed instruction.
// RULE16: Reset sets the mask; clear-mask, wait or a CC byte pulled on return clears it.
// RULE17: Interrupt entry sets the mask after stacking, before vector fetch.
// RULE18: Interrupt stacking order PCL, PCH, X, A, CC; reverse on return.
`timescale 1ns/1ps
`include "cprs_defines.vh"

module cprs_regs #(
  parameter ADDR_BITS = 13                   // Implemented address lines.
) (
  input  wire        clk_sys,                // Core clock.
  input  wire        nrst,                   // Asynchronous reset, active low.
  input  wire        acc_load,               // Load accumulator.
  input  wire [7:0]  acc_data,               // Accumulator load value.
  input  wire        idx_load,               // Load index register.
  input  wire [7:0]  idx_data,               // Index load value.
  input  wire [1:0]  idx_mode,               // Indexed address form.
  input  wire [15:0] idx_offset,             // Immediate offset from instruction.
  input  wire        pc_fetch,               // Instruction or operand fetched.
  input  wire        pc_load,                // Jump, branch or vector load.
  input  wire [15:0] pc_target,              // Non-sequential target.
  input  wire        flags_load,             // Update result flags.
  input  wire [3:0]  flags_data,             // New H,N,Z,C packed as {H,N,Z,C}.
  input  wire        flags_mask,             // Single update enable; all four flags update if set.
  input  wire        stack_top_restore_op,   // Stack top restore instruction.
  input  wire        clear_mask_instruction, // Clear-mask instruction.
  input  wire        wait_op,                // Wait instruction.
  input  wire        set_mask_op,            // Set-mask instruction.
  input  wire        call_start,             // Begin subroutine call stacking.
  input  wire        irq_start,              // Begin interrupt stacking.
  input  wire        rti_start,              // Begin return from interrupt.
  input  wire        rts_start,              // Begin return from subroutine.
  input  wire [7:0]  pull_data,              // Byte read from stack.
  output reg         stack_busy,             // Stacking sequence running.
  output reg         stack_we,               // Write byte to stack this cycle.
  output reg         stack_re,               // Read byte from stack this cycle.
  output wire [15:0] stack_addr,             // Current stack address.
  output reg  [7:0]  push_data,              // Byte to write.
  output reg         vector_fetch,           // Pulse after mask set on entry.
  output wire [15:0] operand_addr,           // Indexed operand address.
  output wire [15:0] fetch_addr,             // Program fetch address.
  output reg  [7:0]  acc,                    // Accumulator.
  output reg  [7:0]  idx,                    // Index register.
  output reg  [15:0] program_counter,        // Program counter.
  output wire [7:0]  condition_flags_reg,    // Condition codes as read.
  output wire [5:0]  stack_pointer           // Stack pointer bits.
);

  // -------------------------------------------------------------
  // Sequencer states
  // -------------------------------------------------------------
  localparam S_IDLE = 2'h0;
  localparam S_PUSH = 2'h1;
  localparam S_PULL = 2'h2;
  localparam S_MASK = 2'h3;

  reg [1:0] state_reg;
  reg [2:0] step_reg;
  reg [2:0] count_reg;
  reg       is_irq_reg;
  reg [3:0] flag_reg;
  reg       mask_reg;
  wire [4:0] cc_reg;
  reg [2:0] cc_rank;
  reg       push;
  reg       pull;

  // Index address forming, shared by both offset modes.
  function [15:0] idx_sum;
    input [7:0]  x;
    input [15:0] off;
    begin
      idx_sum = {8'h00, x} + off;
    end
  endfunction

  assign operand_addr = (idx_mode == `CPRS_IDX_NONE) ? {8'h00, idx} :  // [RULE7]
                        (idx_mode == `CPRS_IDX_OFF8) ?
                        idx_sum(idx, {8'h00, idx_offset[7:0]}) :      // [RULE8]
                        idx_sum(idx, idx_offset);                     // [RULE9]

  assign fetch_addr = {{(16 - ADDR_BITS){1'b0}},
                       program_counter[ADDR_BITS-1:0]};               // [RULE11]

  // Result flags are held as {H,N,Z,C}; the mask sits between H and N.
  assign cc_reg = {flag_reg[3], mask_reg, flag_reg[2:0]};
  assign condition_flags_reg = {`CPRS_CC_UPPER, cc_reg};              // [RULE13]

  // -------------------------------------------------------------
  // Stack pointer
  // -------------------------------------------------------------
  cprs_stack_ptr u_sp (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .sp_reset      (stack_top_restore_op),
    .push          (push),
    .pull          (pull),
    .stack_addr    (stack_addr),
    .stack_pointer (stack_pointer)
  );

  // Push order index for interrupts; calls use the first two.
  always @* begin
    push = (state_reg == S_PUSH);
    pull = (state_reg == S_PULL);
    stack_we = push;
    stack_re = pull;
    stack_busy = (state_reg != S_IDLE);
    case (step_reg)                                                   // [RULE18]
      `CPRS_STK_PCL: push_data = program_counter[7:0];
      `CPRS_STK_PCH: push_data = program_counter[15:8];
      `CPRS_STK_X:   push_data = idx;
      `CPRS_STK_A:   push_data = acc;
      default:       push_data = condition_flags_reg;
    endcase
    // Pull order is the reverse of the push order.
    cc_rank = count_reg - 3'h1 - step_reg;                            // [RULE18]
  end

  // -------------------------------------------------------------
  // Stacking sequencer
  // -------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= S_IDLE;
      step_reg     <= 3'h0;
      count_reg    <= 3'h0;
      is_irq_reg   <= 1'b0;
      vector_fetch <= 1'b0;
    end else begin
      vector_fetch <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          step_reg <= 3'h0;
          if (irq_start) begin
            state_reg  <= S_PUSH;
            count_reg  <= `CPRS_IRQ_BYTES;                           // [RULE5]
            is_irq_reg <= 1'b1;
          end else if (call_start) begin
            state_reg  <= S_PUSH;
            count_reg  <= `CPRS_CALL_BYTES;                          // [RULE5]
            is_irq_reg <= 1'b0;
          end else if (rti_start) begin
            state_reg  <= S_PULL;
            count_reg  <= `CPRS_IRQ_BYTES;
            is_irq_reg <= 1'b1;
          end else if (rts_start) begin
            state_reg  <= S_PULL;
            count_reg  <= `CPRS_CALL_BYTES;
            is_irq_reg <= 1'b0;
          end
        end
        S_PUSH: begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == count_reg - 3'h1) begin
            state_reg <= is_irq_reg ? S_MASK : S_IDLE;
          end
        end
        S_PULL: begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == count_reg - 3'h1) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          vector_fetch <= 1'b1;                                      // [RULE17]
          state_reg    <= S_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Accumulator, index and condition codes
  // -------------------------------------------------------------
  // These keep their contents across reset, so they have no reset branch.
  always @(posedge clk_sys) begin
    if (pull && cc_rank == `CPRS_STK_A) begin
      acc <= pull_data;
    end else if (acc_load) begin
      acc <= acc_data;                                               // [RULE6]
    end
    if (pull && cc_rank == `CPRS_STK_X) begin
      idx <= pull_data;
    end else if (idx_load) begin
      idx <= idx_data;                                               // [RULE10]
    end
  end

  always @(posedge clk_sys) begin
    if (pull && cc_rank == `CPRS_STK_CC) begin
      flag_reg <= {pull_data[`CPRS_CC_H], pull_data[`CPRS_CC_N],
                   pull_data[`CPRS_CC_Z], pull_data[`CPRS_CC_C]};
    end else if (flags_load && flags_mask) begin
      flag_reg <= flags_data;                                        // [RULE15]
    end
  end

  // Only the mask bit has a reset branch.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= 1'b1;                                              // [RULE14] [RULE16]
    end else if (state_reg == S_MASK || set_mask_op) begin
      mask_reg <= 1'b1;                                              // [RULE17]
    end else if (pull && cc_rank == `CPRS_STK_CC) begin
      mask_reg <= pull_data[`CPRS_CC_I];
    end else if (clear_mask_instruction || wait_op) begin
      mask_reg <= 1'b0;                                              // [RULE16]
    end
  end

  // -------------------------------------------------------------
  // Program counter
  // -------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      program_counter <= 16'h0000;
    end else if (pull && cc_rank == `CPRS_STK_PCH) begin
      program_counter[15:8] <= pull_data;
    end else if (pull && cc_rank == `CPRS_STK_PCL) begin
      program_counter[7:0] <= pull_data;
    end else if (pc_load) begin
      program_counter <= pc_target;                                  // [RULE12]
    end else if (pc_fetch) begin
      program_counter <= program_counter + 16'h0001;                 // [RULE12] [RULE11]
    end
  end

endmodule // cprs_regs

// *** testbench/cprs_regs_assertions.sv ***
// Port checker for the register set.
// Assumes a bind to cprs_regs, whose port names it reuses.
`timescale 1ns/1ps
module cprs_chk (
  input wire        clk_sys,                // Clock.
  input wire        nrst,                   // Reset.
  input wire [1:0]  idx_mode,               // Index form.
  input wire [15:0] idx_offset,             // Offset.
  input wire [7:0]  idx,                    // Index.
  input wire        pc_fetch,               // Fetch.
  input wire        pc_load,                // Load.
  input wire [15:0] pc_target,              // Target.
  input wire [15:0] program_counter,        // Counter.
  input wire        stack_top_restore_op,   // Top restore.
  input wire        clear_mask_instruction, // Mask clear.
  input wire        wait_op,                // Wait.
  input wire        irq_start,              // Entry.
  input wire        stack_busy,             // Busy.
  input wire        stack_we,               // Push.
  input wire        stack_re,               // Pull.
  input wire [15:0] stack_addr,             // Address.
  input wire [5:0]  stack_pointer,          // Pointer.
  input wire        vector_fetch,           // Vector.
  input wire [15:0] operand_addr,           // Operand.
  input wire [7:0]  condition_flags_reg     // Flags.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_STK_ADDR: assert property (stack_addr == {10'h003, stack_pointer})
    else $error("stack address form wrong");
  AST_TOP: assert property (stack_top_restore_op |=> stack_pointer == 6'h3f)
    else $error("top restore missed");
  AST_PUSH: assert property (stack_we && !stack_top_restore_op |=>
    stack_pointer == $past(stack_pointer) - 6'h01) else $error("push step wrong");
  AST_PULL: assert property (stack_re && !stack_top_restore_op |=>
    stack_pointer == $past(stack_pointer) + 6'h01) else $error("pull step wrong");
  AST_IDX0: assert property (idx_mode == 2'h0 |-> operand_addr == {8'h00, idx})
    else $error("no offset address wrong");
  AST_IDX8: assert property (idx_mode == 2'h1 |->
    operand_addr == {8'h00, idx} + {8'h00, idx_offset[7:0]}) else $error("short offset wrong");
  AST_IDX16: assert property (idx_mode == 2'h2 |->
    operand_addr == {8'h00, idx} + idx_offset) else $error("long offset wrong");
  AST_PC: assert property (pc_fetch && !pc_load |=>
    program_counter == $past(program_counter) + 16'h0001) else $error("pc step wrong");
  AST_PC_LOAD: assert property (pc_load |=> program_counter == $past(pc_target))
    else $error("pc load wrong");
  AST_UPPER: assert property (condition_flags_reg[7:5] == 3'h7)
    else $error("upper flag bits not ones");
  AST_MASK_CLR: assert property ($fell(condition_flags_reg[3]) |->
    $past(clear_mask_instruction) || $past(wait_op) || $past(stack_re))
    else $error("mask cleared without cause");
  AST_IRQ_SEQ: assert property (irq_start && !stack_busy |=>
    stack_we [*5] ##2 vector_fetch) else $error("entry sequence wrong");
  AST_VEC_MASK: assert property (vector_fetch |-> condition_flags_reg[3])
    else $error("vector before mask");
endmodule // cprs_chk

bind cprs_regs cprs_chk u_cprs_chk (.*);

// *** testbench/tb.sv ***
// Self-checking bench for the register set.
// Assumes cprs_regs and its checker are compiled first.
`timescale 1ns/1ps
module tb;
  logic        clk_sys, nrst, acc_load, idx_load, pc_fetch, pc_load, flags_load, flags_mask;
  logic        stack_top_restore_op, clear_mask_instruction, wait_op, set_mask_op;
  logic        call_start, irq_start, rti_start, rts_start;
  logic [7:0]  acc_data, idx_data, pull_data;
  logic [1:0]  idx_mode;
  logic [15:0] idx_offset, pc_target;
  logic [3:0]  flags_data;
  wire         stack_busy, stack_we, stack_re, vector_fetch;
  wire  [15:0] stack_addr, operand_addr, fetch_addr, program_counter;
  wire  [7:0]  push_data, acc, idx, condition_flags_reg;
  wire  [5:0]  stack_pointer;
  int          n_errors, compares, n, tot;
  logic        vf;
  logic [7:0]  pd [8];
  logic [15:0] pa [8];
  logic [7:0]  pv [8];
  logic [7:0]  ex [5];

  cprs_regs u_cprs_regs (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task conclude;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Drops the start strobe, logs stack traffic and feeds pull bytes.
  task run;
    n = 0;
    vf = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      {call_start, irq_start, rti_start, rts_start} <= 4'h0;
      pull_data <= pv[n[2:0]];
      #1;
      if (stack_we && n < 8) begin
        pd[n] = push_data;
        pa[n] = stack_addr;
        n++;
      end
      if (stack_re && n < 8) begin
        n++;
      end
      vf = vf | vector_fetch;
    end
    chk(stack_busy, 16'h0000, "still busy");
  endtask

  task t_keep;
    @(posedge clk_sys);
    {acc_load, idx_load, flags_load, flags_mask, clear_mask_instruction} <= 5'h1f;
    {acc_data, idx_data, flags_data} <= {8'ha5, 8'h3c, 4'h9};
    @(posedge clk_sys);
    {acc_load, idx_load, flags_load, flags_mask, clear_mask_instruction} <= 5'h00;
    #1;
    chk(condition_flags_reg, 16'h00f1, "flag load");
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk(acc, 16'h00a5, "acc lost");
    chk(idx, 16'h003c, "idx lost");
    chk(condition_flags_reg, 16'h00f9, "flags after reset");
    chk(stack_addr, 16'h00ff, "stack top");
    @(posedge clk_sys);
    wait_op <= 1'b1;
    @(posedge clk_sys);
    wait_op <= 1'b0;
    #1;
    chk(condition_flags_reg, 16'h00f1, "wait clear");
  endtask

  task t_index;
    logic [15:0] e [4];
    e = '{16'h00f0, 16'h0124, 16'h1324, 16'h1324};
    @(posedge clk_sys);
    {idx_load, idx_data, idx_offset} <= {1'b1, 8'hf0, 16'h1234};
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      idx_load <= 1'b0;
      idx_mode <= m[1:0];
      #1;
      chk(operand_addr, e[m], "operand");
    end
  endtask

  task t_pc;
    @(posedge clk_sys);
    {pc_load, pc_target} <= {1'b1, 16'hfffe};
    @(posedge clk_sys);
    {pc_load, pc_fetch} <= 2'b01;
    #1;
    chk(fetch_addr, 16'h1ffe, "fetch address");
    repeat (3) @(posedge clk_sys);
    pc_fetch <= 1'b0;
    #1;
    chk(program_counter, 16'h0001, "pc advance");
  endtask

  task t_irq;
    ex = '{8'h01, 8'h00, 8'hf0, 8'ha5, 8'hf1};
    pv = '{8'hf1, 8'h5a, 8'h0f, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00};
    @(posedge clk_sys);
    irq_start <= 1'b1;
    run;
    chk(n[15:0], 16'd5, "entry bytes");
    for (int k = 0; k < 5; k++) begin
      chk(pd[k], ex[k], "push data");
      chk(pa[k], 16'h00ff - k[15:0], "push address");
    end
    chk(vf, 16'h0001, "no vector");
    chk(condition_flags_reg, 16'h00f9, "entry mask");
    @(posedge clk_sys);
    rti_start <= 1'b1;
    run;
    chk({acc, idx}, 16'h5a0f, "pull a x");
    chk(program_counter, 16'h1234, "pull pc");
    chk(condition_flags_reg, 16'h00f1, "pull flags");
    chk(stack_pointer, 16'h003f, "pull pointer");
  endtask

  task t_wrap;
    tot = 0;
    for (int c = 0; c < 33; c++) begin
      @(posedge clk_sys);
      call_start <= 1'b1;
      run;
      tot += n;
      if (c == 31) chk(pa[1], 16'h00c0, "lowest");
    end
    chk(tot[15:0], 16'd66, "call bytes");
    chk(stack_pointer, 16'h003d, "wrap");
    @(posedge clk_sys);
    stack_top_restore_op <= 1'b1;
    @(posedge clk_sys);
    stack_top_restore_op <= 1'b0;
    #1;
    chk(stack_pointer, 16'h003f, "top restore");
    @(posedge clk_sys);
    rts_start <= 1'b1;
    run;
    chk({n[7:0], 2'b00, stack_pointer}, 16'h0201, "return wrap");
    @(posedge clk_sys);
    set_mask_op <= 1'b1;
    @(posedge clk_sys);
    set_mask_op <= 1'b0;
    #1;
    chk(condition_flags_reg, 16'h00f9, "set mask");
  endtask

  initial begin
    // Known register contents are loaded while reset is held.
    {nrst, acc_load, idx_load, pc_fetch, pc_load, flags_load, flags_mask} = 7'h33;
    {stack_top_restore_op, clear_mask_instruction, wait_op, set_mask_op} = 4'h0;
    {call_start, irq_start, rti_start, rts_start, idx_mode, flags_data} = 10'h000;
    {acc_data, idx_data, pull_data, idx_offset, pc_target} = 56'h0;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    {acc_load, idx_load, flags_load, flags_mask} <= 4'h0;
    t_keep;
    t_index;
    t_pc;
    t_irq;
    t_wrap;
    conclude;
  end
endmodule // tb
